// file: hdl/ior_pkg.sv
package ior_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int OP_W = 16;
	localparam int BANK_W = 4;

	// ----------------------------------------------------------------
	// opcode fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_OR_IMM = 8'h09;
	localparam logic [5:0] OP_OR_FILE = 6'h04;
	localparam int IMM_HI = 15;
	localparam int IMM_LO = 8;
	localparam int FILE_HI = 15;
	localparam int FILE_LO = 10;
	localparam int DEST_BIT = 9;
	localparam int BANK_BIT = 8;

	// ----------------------------------------------------------------
	// addressing
	// ----------------------------------------------------------------
	localparam logic [7:0] INDEXED_MAX = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

	// ----------------------------------------------------------------
	// reset value and skip no-op counts
	// ----------------------------------------------------------------
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [1:0] NOP_ONE = 2'h1;
	localparam logic [1:0] NOP_TWO = 2'h2;

	// ----------------------------------------------------------------
	// instruction cycle phases
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_DECODE = 2'b00,
		PH_READ = 2'b01,
		PH_PROCESS = 2'b10,
		PH_WRITE = 2'b11
	} ior_phase_t;
endpackage : ior_pkg

// file: hdl/ior_addr_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ior_addr_if;
	logic [7:0] file_sel;
	logic bank_access;
	logic ext_en;
	logic [3:0] bank_sel;
	logic [11:0] index_base;
	logic [11:0] addr;

	modport core (output file_sel, output bank_access, output ext_en, output bank_sel, output index_base,
		input addr);
	modport former (input file_sel, input bank_access, input ext_en, input bank_sel, input index_base,
		output addr);
endinterface : ior_addr_if
`default_nettype wire

// file: hdl/ior_addr.sv
`timescale 1ns/100ps
`default_nettype none
module ior_addr (
	// address request
	ior_addr_if.former a_if
);
	logic [12:0] idx_sum;

	always_comb begin
		// indexed address wraps in 12 bits
		idx_sum = {1'b0, a_if.index_base} + {5'h00, a_if.file_sel};
		if (a_if.bank_access) begin
			a_if.addr = {a_if.bank_sel, a_if.file_sel};
		end else if (a_if.ext_en && (a_if.file_sel <= ior_pkg::INDEXED_MAX)) begin
			a_if.addr = idx_sum[11:0];
		end else if (a_if.file_sel < ior_pkg::ACCESS_SPLIT) begin
			a_if.addr = {4'h0, a_if.file_sel};
		end else begin
			a_if.addr = {ior_pkg::ACCESS_HI_BANK, a_if.file_sel};
		end
	end
endmodule : ior_addr
`default_nettype wire

// file: hdl/ior_exec.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - The OR-immediate instruction ORs the accumulator with the opcode's low byte and writes the accumulator.
// - The OR-with-file instruction ORs accumulator and file register, result to accumulator if d=0, file if d=1.
// - Bank bit 0 addresses the quick access bank; bank bit 1 uses the bank select register with the file field.
// - Bank bit 0 with extended set enabled and file field up to 95 uses indexed literal offset addressing.
// - A taken skip makes the next instruction one no-operation cycle, or two when it has two words.
module ior_exec (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// instruction stream
	input wire logic [15:0] instr_i,
	output logic instr_take_o,
	input wire logic skip_i,
	input wire logic skip_two_word_i,
	// addressing context
	input wire logic ext_set_en_i,
	input wire logic [3:0] bank_select_register_i,
	input wire logic [11:0] index_base_i,
	// data memory
	output logic [11:0] mem_addr_o,
	output logic mem_rd_o,
	input wire logic [7:0] mem_rdata_i,
	output logic mem_we_o,
	output logic [7:0] mem_wdata_o,
	// core state
	output logic [7:0] acc_o,
	output logic neg_o,
	output logic zero_o,
	output logic [1:0] phase_o,
	output logic nop_cycle_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ior_pkg::ior_phase_t phase_reg, phase_next;
	logic [15:0] op_reg, op_next;
	logic [1:0] nop_reg, nop_next;
	logic cur_nop_reg, cur_nop_next;
	logic [7:0] acc_reg, acc_next;
	logic [7:0] res_reg, res_next;
	logic neg_reg, neg_next;
	logic zero_reg, zero_next;
	logic [11:0] addr_reg, addr_next;
	logic rd_reg, rd_next;
	logic we_reg, we_next;
	logic [7:0] wdata_reg, wdata_next;
	logic take_reg, take_next;
	logic is_imm;
	logic is_file;
	logic [7:0] operand;
	logic [7:0] or_result;

	ior_addr_if a_if ();

	// ----------------------------------------------------------------
	// address forming
	// ----------------------------------------------------------------
	assign a_if.file_sel = op_reg[7:0];
	assign a_if.bank_access = op_reg[ior_pkg::BANK_BIT];
	assign a_if.ext_en = ext_set_en_i;
	assign a_if.bank_sel = bank_select_register_i;
	assign a_if.index_base = index_base_i;

	ior_addr u_addr (
		.a_if(a_if.former)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	assign is_imm = !cur_nop_reg && (op_reg[ior_pkg::IMM_HI:ior_pkg::IMM_LO] == ior_pkg::OP_OR_IMM);
	assign is_file = !cur_nop_reg && (op_reg[ior_pkg::FILE_HI:ior_pkg::FILE_LO] == ior_pkg::OP_OR_FILE);
	assign operand = is_imm ? op_reg[7:0] : mem_rdata_i;

	// ----------------------------------------------------------------
	// per-bit inclusive or
	// ----------------------------------------------------------------
	for (genvar bit_idx = 0; bit_idx < 8; bit_idx++) begin : g_or
		assign or_result[bit_idx] = acc_reg[bit_idx] | operand[bit_idx];
	end

	// ----------------------------------------------------------------
	// phase sequencing
	// ----------------------------------------------------------------
	always_comb begin
		phase_next = phase_reg;
		op_next = op_reg;
		take_next = 1'b0;
		case (phase_reg)
			ior_pkg::PH_DECODE: begin
				op_next = instr_i;
				phase_next = ior_pkg::PH_READ;
			end
			ior_pkg::PH_READ: begin
				phase_next = ior_pkg::PH_PROCESS;
			end
			ior_pkg::PH_PROCESS: begin
				phase_next = ior_pkg::PH_WRITE;
			end
			ior_pkg::PH_WRITE: begin
				take_next = 1'b1;
				phase_next = ior_pkg::PH_DECODE;
			end
			default: begin
				phase_next = ior_pkg::PH_DECODE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			phase_reg <= ior_pkg::PH_DECODE;
			op_reg <= 16'h0000;
			take_reg <= 1'b1;
		end else begin
			phase_reg <= phase_next;
			op_reg <= op_next;
			take_reg <= take_next;
		end
	end

	// ----------------------------------------------------------------
	// skip no-op count
	// ----------------------------------------------------------------
	always_comb begin
		nop_next = nop_reg;
		cur_nop_next = cur_nop_reg;
		if (phase_reg == ior_pkg::PH_DECODE) begin
			cur_nop_next = (nop_reg != 2'h0);
			if (nop_reg != 2'h0) begin
				nop_next = nop_reg - 2'h1;
			end
		end
		// a new skip wins over the decrement
		if (skip_i) begin
			nop_next = skip_two_word_i ? ior_pkg::NOP_TWO : ior_pkg::NOP_ONE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			nop_reg <= 2'h0;
			cur_nop_reg <= 1'b0;
		end else begin
			nop_reg <= nop_next;
			cur_nop_reg <= cur_nop_next;
		end
	end

	// ----------------------------------------------------------------
	// accumulator and flags
	// ----------------------------------------------------------------
	always_comb begin
		acc_next = acc_reg;
		res_next = res_reg;
		neg_next = neg_reg;
		zero_next = zero_reg;
		case (phase_reg)
			ior_pkg::PH_PROCESS: begin
				res_next = or_result;
			end
			ior_pkg::PH_WRITE: begin
				if (is_imm || (is_file && !op_reg[ior_pkg::DEST_BIT])) begin
					acc_next = res_reg;
				end
				if (is_imm || is_file) begin
					neg_next = res_reg[7];
					zero_next = (res_reg == 8'h00);
				end
			end
			default: begin
				acc_next = acc_reg;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			acc_reg <= ior_pkg::ACC_RST;
			res_reg <= 8'h00;
			neg_reg <= 1'b0;
			zero_reg <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			res_reg <= res_next;
			neg_reg <= neg_next;
			zero_reg <= zero_next;
		end
	end

	// ----------------------------------------------------------------
	// memory strobes
	// ----------------------------------------------------------------
	always_comb begin
		addr_next = addr_reg;
		rd_next = 1'b0;
		we_next = 1'b0;
		wdata_next = wdata_reg;
		case (phase_reg)
			ior_pkg::PH_READ: begin
				if (is_file) begin
					addr_next = a_if.addr;
					rd_next = 1'b1;
				end
			end
			ior_pkg::PH_PROCESS: begin
				if (is_file && op_reg[ior_pkg::DEST_BIT]) begin
					we_next = 1'b1;
					wdata_next = or_result;
				end
			end
			default: begin
				rd_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			addr_reg <= 12'h000;
			rd_reg <= 1'b0;
			we_reg <= 1'b0;
			wdata_reg <= 8'h00;
		end else begin
			addr_reg <= addr_next;
			rd_reg <= rd_next;
			we_reg <= we_next;
			wdata_reg <= wdata_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign instr_take_o = take_reg;
	assign mem_addr_o = addr_reg;
	assign mem_rd_o = rd_reg;
	assign mem_we_o = we_reg;
	assign mem_wdata_o = wdata_reg;
	assign acc_o = acc_reg;
	assign neg_o = neg_reg;
	assign zero_o = zero_reg;
	assign phase_o = phase_reg;
	assign nop_cycle_o = cur_nop_reg;
endmodule : ior_exec
`default_nettype wire

// file: test/ior_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module ior_assertions (
	// watched ports
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [15:0] instr_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic instr_take_o,
	input wire logic mem_rd_o,
	input wire logic mem_we_o,
	input wire logic [7:0] mem_wdata_o,
	input wire logic [7:0] acc_o,
	input wire logic [1:0] phase_o,
	input wire logic nop_cycle_o
);
	// ----------------
	// properties
	// ----------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_rest; phase_o == 2'h1 ##1 phase_o == 2'h2 ##1 phase_o == 2'h3 ##1 phase_o == 2'h0; endsequence
	property p_phase; resetn_i && phase_o == 2'h0 |=> s_rest; endproperty
	a_phase: assert property (p_phase) else $error("phase order");
	property p_take; instr_take_o == (phase_o == 2'h0); endproperty
	a_take: assert property (p_take) else $error("take phase");
	property p_rd; mem_rd_o |-> phase_o == 2'h2 && $past(instr_i[15:10], 2) == 6'h04 ##1 !mem_rd_o; endproperty
	a_rd: assert property (p_rd) else $error("read strobe");
	property p_we; mem_we_o |-> $past(mem_rd_o) && $past(instr_i[9], 3) && phase_o == 2'h3; endproperty
	a_we: assert property (p_we) else $error("write strobe");
	property p_wd; mem_we_o |-> mem_wdata_o == (acc_o | $past(mem_rdata_i)); endproperty
	a_wd: assert property (p_wd) else $error("write data");
	property p_imm;
		phase_o == 2'h3 && !nop_cycle_o && $past(instr_i[15:8], 3) == 8'h09
		|=> acc_o == ($past(acc_o) | $past(instr_i[7:0], 4));
	endproperty
	a_imm: assert property (p_imm) else $error("immediate or");
	property p_hold; phase_o != 2'h3 |=> $stable(acc_o); endproperty
	a_hold: assert property (p_hold) else $error("acc moved");
	property p_nop;
		nop_cycle_o && phase_o == 2'h1 |-> (nop_cycle_o && !mem_rd_o && !mem_we_o)[*3] ##1 $stable(acc_o);
	endproperty
	a_nop: assert property (p_nop) else $error("no-op cycle");
endmodule : ior_assertions
bind ior_exec ior_assertions ior_assertions_i (.clk_i, .resetn_i, .instr_i, .mem_rdata_i, .instr_take_o,
	.mem_rd_o, .mem_we_o, .mem_wdata_o, .acc_o, .phase_o, .nop_cycle_o);
`default_nettype wire

// file: test/ior_exec_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module ior_exec_tb_top;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [15:0] instr_i = 16'h0000;
	logic skip_i = 1'b0;
	logic skip_two_word_i = 1'b0;
	logic ext_set_en_i = 1'b0;
	logic [3:0] bank_select_register_i = 4'h0;
	logic [11:0] index_base_i = 12'h000;
	logic [7:0] mem_rdata_i = 8'h00;
	logic instr_take_o, mem_rd_o, mem_we_o, neg_o, zero_o, nop_cycle_o;
	logic [11:0] mem_addr_o;
	logic [7:0] mem_wdata_o, acc_o, m_acc;
	logic [1:0] phase_o;
	logic m_n, m_z;
	logic [31:0] seed = 32'h0000002c;
	int errors = 0;
	int cmp_count = 0;
	bit nop_q[$];
	always #5 clk_i = ~clk_i;
	ior_exec ior_exec_i (.clk_i, .resetn_i, .instr_i, .instr_take_o, .skip_i, .skip_two_word_i, .ext_set_en_i,
		.bank_select_register_i, .index_base_i, .mem_addr_o, .mem_rd_o, .mem_rdata_i, .mem_we_o, .mem_wdata_o,
		.acc_o, .neg_o, .zero_o, .phase_o, .nop_cycle_o);
	// ----------------
	// model and drivers
	// ----------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic wp(input logic [1:0] p);
		do @(posedge clk_i); while (phase_o !== p);
	endtask : wp
	task automatic rst();
		resetn_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		resetn_i <= 1'b1;
		m_acc = 8'h00;
		m_n = 1'b0;
		m_z = 1'b0;
		nop_q.delete();
	endtask : rst
	task automatic ex(input logic [15:0] op, input logic sk, input logic tw);
		logic [31:0] v;
		logic nop;
		logic fl;
		logic [7:0] r;
		logic [11:0] ea;
		v = rnd();
		nop = nop_q.size() > 0;
		if (nop) void'(nop_q.pop_front());
		fl = !nop && op[15:10] == 6'h04;
		instr_i <= op;
		skip_i <= 1'b0;
		bank_select_register_i <= v[3:0];
		ext_set_en_i <= v[4];
		index_base_i <= v[27:16];
		mem_rdata_i <= v[15:8];
		if (op[8]) ea = {v[3:0], op[7:0]};
		else if (v[4] && op[7:0] <= 8'h5f) ea = v[27:16] + {4'h0, op[7:0]};
		else ea = {(op[7:0] < 8'h60) ? 4'h0 : 4'hf, op[7:0]};
		r = (op[15:8] == 8'h09) ? op[7:0] : v[15:8];
		wp(2'h0);
		`CHK("take", 1'b1, instr_take_o)
		`CHK("acc", m_acc, acc_o)
		`CHK("neg", m_n, neg_o)
		`CHK("zero", m_z, zero_o)
		wp(2'h1);
		`CHK("nop", nop, nop_cycle_o)
		wp(2'h2);
		`CHK("rd", fl, mem_rd_o)
		if (fl) `CHK("addr", ea, mem_addr_o)
		skip_i <= sk && !nop;
		skip_two_word_i <= tw;
		wp(2'h3);
		`CHK("we", fl && op[9], mem_we_o)
		if (fl && op[9]) `CHK("wdata", m_acc | r, mem_wdata_o)
		if (!nop && (fl || op[15:8] == 8'h09)) begin
			m_n = r[7] | m_acc[7];
			m_z = (m_acc | r) == 8'h00;
			if (!(fl && op[9])) m_acc = m_acc | r;
		end
		if (sk && !nop) begin
			nop_q.delete();
			repeat (tw ? 2 : 1) nop_q.push_back(1'b1);
		end
	endtask : ex
	initial begin
		logic [31:0] w;
		logic [15:0] op;
		rst();
		ex(16'h0900, 1'b0, 1'b0);
		ex(16'h099a, 1'b0, 1'b0);
		ex(16'h0935, 1'b0, 1'b0);
		$display("immediate test done");
		for (int i = 0; i < 64; i++) begin
			if (i % 16 == 15) rst();
			w = rnd();
			op = w[0] ? {8'h09, w[15:8]} : {6'h04, w[2:1], w[15:8]};
			if (w[3]) op[7:0] = (i % 2 == 1) ? 8'h5f : 8'h60;
			if (w[4] && w[5]) op = {8'h0a, w[15:8]};
			ex(op, w[6] & w[7], w[8]);
		end
		ex(16'h0000, 1'b0, 1'b0);
		$display("random test done");
		test_done();
	end
	initial begin
		#20000;
		errors++;
		test_done();
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done
endmodule : ior_exec_tb_top
`default_nettype wire
